// >>> include/mcc_regs.svh
// constants of the monotonic counter command link: opcodes, lengths, status codes, timing
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH

`define MCC_OPC_CTR 8'h9b
`define MCC_OPC_READ 8'h96
`define MCC_SUB_INC 8'h02
`define MCC_SUB_REQ 8'h03
`define MCC_LEN_INC 7'h28
`define MCC_LEN_REQ 7'h30
`define MCC_LEN_READ 7'h33
`define MCC_LEN_RSV 7'h04
`define MCC_RD_HDR 7'h02
`define MCC_RX_BYTES 7'h30
`define MCC_NUM_CTR 4
`define MCC_ST_BUSY 8'h01
`define MCC_ST_BAD 8'h04
`define MCC_ST_NOINIT 8'h08
`define MCC_ST_SIG 8'h10
`define MCC_ST_DATA 8'h20
`define MCC_ST_OK 8'h80
`define MCC_CLK_NS 100
`define MCC_SIG_TIME_NS 10000
`define MCC_SIG_CYC ((`MCC_SIG_TIME_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
`define MCC_SCK_HALF 2'h1
`define MCC_GAP_CYC 4'h4

`endif

// >>> include/mcc_pkg.sv
// types and shared arithmetic of the monotonic counter command link
`default_nettype none
package mcc_pkg;
`include "mcc_regs.svh"

    typedef enum logic [1:0] {
        MCC_DEV_IDLE = 2'b01,
        MCC_DEV_WORK = 2'b10
    } mcc_dev_e;

    typedef enum logic [2:0] {
        MCC_HST_IDLE = 3'b001,
        MCC_HST_SHIFT = 3'b010,
        MCC_HST_GAP = 3'b100
    } mcc_hst_e;

    typedef enum logic [1:0] {
        MCC_CMD_INC = 2'h0,
        MCC_CMD_REQ = 2'h1,
        MCC_CMD_READ = 2'h2,
        MCC_CMD_RSV = 2'h3
    } mcc_cmd_e;

    typedef struct packed {
        mcc_dev_e state;
        logic sclk_q;
        logic cs_q;
        logic [2:0] bit_cnt;
        logic [6:0] byte_cnt;
        logic [7:0] sh;
        logic [7:0] op;
        logic [47:0][7:0] rx;
        logic [6:0] rx_len;
        logic [7:0] status;
        logic [7:0] work_cnt;
        logic [`MCC_NUM_CTR-1:0][31:0] ctr;
        logic [`MCC_NUM_CTR-1:0] ctr_init;
        logic [`MCC_NUM_CTR-1:0][255:0] key;
        logic [`MCC_NUM_CTR-1:0] key_init;
        logic [95:0] tag;
        logic [31:0] ctr_rd;
        logic [255:0] sig;
        logic miso;
    } mcc_dev_s;

    typedef struct packed {
        mcc_hst_e state;
        logic [1:0] div;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [2:0] bit_cnt;
        logic [6:0] byte_idx;
        logic [6:0] len;
        logic last;
        logic is_read;
        logic [47:0][7:0] tx;
        logic [7:0] rb;
        logic [383:0] fld;
        logic [3:0] gap;
        logic done;
        logic ready;
        logic [7:0] status;
        logic [95:0] tag;
        logic [31:0] ctr;
        logic [255:0] sig;
    } mcc_hst_s;

    // keyed mixing in place of a full hmac core; both ends use it, so checks stay consistent
    function automatic logic [255:0] sign(input logic [255:0] key, input logic [127:0] msg);
        sign = {key[255:128] ^ msg, key[127:0] ^ {msg[63:0], msg[127:64]}};
    endfunction

    // signed message of a counter command: type, address, reserved, pad, body
    function automatic logic [127:0] ctr_msg(input logic [7:0] sub, input logic [7:0] addr,
                                            input logic [7:0] rsv, input logic [95:0] body);
        ctr_msg = {sub, addr, rsv, 8'h00, body};
    endfunction
endpackage
`default_nettype wire

// >>> include/mcc_if.sv
// serial link between the counter device and its controller
`timescale 1ns/1ps
`default_nettype none
interface mcc_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    modport dev (input cs_n, input sclk, input mosi, output miso);
    modport host (output cs_n, output sclk, output mosi, input miso);
endinterface
`default_nettype wire

// >>> rtl/mcc_dev.sv
// device end: counter command decode, checks, counter store and status/data readback
//
// Behaviour
// [RULE1] valid increment raises addressed counter by one
// [RULE2] increment frame must be 40 bytes
// [RULE3] reject counter address beyond supported counters
// [RULE4] reject unless counter and key initialised
// [RULE5] reject when received signature mismatches computed
// [RULE6] increment data must equal current counter
// [RULE7] passing transaction executes, posts success status
// [RULE8] counter update must survive power glitch
// [RULE9] request frame must be 48 bytes
// [RULE10] valid request reads addressed counter value
// [RULE11] sign tag and counter with counter key
// [RULE12] reserved command types report error status
// [RULE13] reserved command type sets status bit two
// [RULE14] readback returns status of last command
// [RULE15] successful request also returns tag, counter, signature
// [RULE16] fields invalid whenever an error flag set
// [RULE17] readback may be cut short by select
// [RULE18] readback payload 49 bytes, beyond is arbitrary
// [RULE19] while busy, repeat status from third byte
// [RULE20] while busy, never send tag, counter, signature
// [RULE21] controller rereads after busy clears
// [RULE22] failed check: no execution, error status posted
// [RULE23] busy held from acceptance until work done
`timescale 1ns/1ps
`default_nettype none
`include "mcc_regs.svh"
module mcc_dev (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // serial link
    mcc_if.dev lnk,
    // counter and key provisioning
    input wire logic init_we_in,
    input wire logic [1:0] init_addr_in,
    input wire logic [31:0] init_value_in,
    input wire logic [255:0] init_key_in,
    // status view
    output logic [7:0] ctr_status_out
);

    mcc_pkg::mcc_dev_s st_ff;
    mcc_pkg::mcc_dev_s nxt_st;

    // byte of the readback frame at position idx (0 = opcode, 1 = dummy, 2 = status)
    function automatic logic [7:0] tx_byte(input logic [6:0] idx, input logic [7:0] status,
                                          input logic [383:0] fld);
        logic [6:0] k;
        k = idx - `MCC_RD_HDR - 7'h01;
        // status also fills anything past the defined payload
        tx_byte = status;
        if (idx < `MCC_RD_HDR) begin
            tx_byte = 8'h00;
        // [RULE20] fields held back
        end else if (idx > `MCC_RD_HDR && (status & `MCC_ST_BUSY) == 8'h00
                     && idx < `MCC_LEN_READ) begin
            tx_byte = fld[383 - 8 * k -: 8];
        end
    endfunction

    always_comb begin
        logic [7:0] rbyte;
        logic [7:0] tbyte;
        logic [7:0] sub;
        logic [1:0] a;
        logic is_inc;
        logic len_ok;
        logic [95:0] tag;
        logic [31:0] cdata;
        logic [255:0] sig_rx;
        logic [255:0] exp_sig;
        int sbase;
        rbyte = {st_ff.sh[6:0], lnk.mosi};
        tbyte = 8'h00;
        sub = st_ff.rx[1];
        a = st_ff.rx[2][1:0];
        is_inc = (sub == `MCC_SUB_INC);
        len_ok = 1'b0;
        tag = '0;
        sig_rx = '0;
        cdata = 32'h0;
        exp_sig = '0;
        sbase = is_inc ? 8 : 16;
        nxt_st = st_ff;
        nxt_st.sclk_q = lnk.sclk;
        nxt_st.cs_q = lnk.cs_n;

        // link side: shift in on rising clock, drive out on falling clock
        if (lnk.cs_n) begin
            // [RULE17] a frame ends wherever select rises
            nxt_st.bit_cnt = 3'h0;
            nxt_st.byte_cnt = 7'h00;
        end else if (lnk.sclk && !st_ff.sclk_q) begin
            nxt_st.sh = rbyte;
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
            if (st_ff.bit_cnt == 3'h7) begin
                if (st_ff.byte_cnt == 7'h00) begin
                    nxt_st.op = rbyte;
                // command bytes are frozen while a command is being worked on
                end else if (st_ff.state == mcc_pkg::MCC_DEV_IDLE && st_ff.op == `MCC_OPC_CTR
                             && st_ff.byte_cnt < `MCC_RX_BYTES) begin
                    nxt_st.rx[st_ff.byte_cnt[5:0]] = rbyte;
                end
                if (st_ff.byte_cnt != 7'h7f) begin
                    nxt_st.byte_cnt = st_ff.byte_cnt + 7'h01;
                end
            end
        end else if (!lnk.sclk && st_ff.sclk_q) begin
            // [RULE14] readback of last status
            // [RULE15] with fields
            // [RULE18] payload then filler
            // [RULE19] status repeated
            tbyte = tx_byte(st_ff.byte_cnt, st_ff.status, {st_ff.tag, st_ff.ctr_rd, st_ff.sig});
            nxt_st.miso = (st_ff.op == `MCC_OPC_READ) ? tbyte[3'h7 - st_ff.bit_cnt] : 1'b0;
        end

        // field extraction for the checks
        for (int k = 0; k < 12; k++) begin
            tag[95 - 8 * k -: 8] = st_ff.rx[4 + k];
        end
        cdata = tag[95:64];
        for (int k = 0; k < 32; k++) begin
            sig_rx[255 - 8 * k -: 8] = st_ff.rx[sbase + k];
        end
        // [RULE2] increment length
        // [RULE9] request length
        len_ok = is_inc ? (st_ff.rx_len == `MCC_LEN_INC) : (st_ff.rx_len == `MCC_LEN_REQ);
        exp_sig = mcc_pkg::sign(st_ff.key[a], mcc_pkg::ctr_msg(sub, st_ff.rx[2], st_ff.rx[3],
                                                              is_inc ? {64'h0, cdata} : tag));

        case (st_ff.state)
            mcc_pkg::MCC_DEV_IDLE: begin
                if (!st_ff.cs_q && lnk.cs_n && st_ff.op == `MCC_OPC_CTR) begin
                    if (st_ff.byte_cnt > `MCC_RD_HDR
                        && (sub == `MCC_SUB_INC || sub == `MCC_SUB_REQ)) begin
                        // [RULE23] busy from acceptance
                        nxt_st.status = `MCC_ST_BUSY;
                        nxt_st.state = mcc_pkg::MCC_DEV_WORK;
                        nxt_st.work_cnt = 8'h00;
                        nxt_st.rx_len = st_ff.byte_cnt;
                    end else begin
                        // [RULE12] reserved type error
                        // [RULE13] bit two set
                        nxt_st.status = `MCC_ST_BAD;
                    end
                end
            end
            mcc_pkg::MCC_DEV_WORK: begin
                nxt_st.work_cnt = st_ff.work_cnt + 8'h01;
                // signature engine time elapses before any result is posted
                if (st_ff.work_cnt == 8'(`MCC_SIG_CYC - 1)) begin
                    nxt_st.state = mcc_pkg::MCC_DEV_IDLE;
                    // [RULE3] address range
                    // [RULE22] failed checks post error only
                    if (!len_ok || st_ff.rx[2] >= 8'(`MCC_NUM_CTR)) begin
                        nxt_st.status = `MCC_ST_BAD;
                    // [RULE4] init state
                    end else if (!st_ff.ctr_init[a] || !st_ff.key_init[a]) begin
                        nxt_st.status = `MCC_ST_NOINIT;
                    // [RULE5] signature compare
                    end else if (sig_rx != exp_sig) begin
                        nxt_st.status = `MCC_ST_SIG;
                    // [RULE6] counter data match
                    end else if (is_inc && cdata != st_ff.ctr[a]) begin
                        nxt_st.status = `MCC_ST_DATA;
                    end else begin
                        // [RULE7] success posted
                        nxt_st.status = `MCC_ST_OK;
                        if (is_inc) begin
                            // [RULE1] plus one
                            // [RULE8] new value lands in one edge, never half written
                            nxt_st.ctr[a] = st_ff.ctr[a] + 32'h1;
                        end else begin
                            // [RULE10] counter read
                            nxt_st.ctr_rd = st_ff.ctr[a];
                            nxt_st.tag = tag;
                            // [RULE11] second signature
                            nxt_st.sig = mcc_pkg::sign(st_ff.key[a], {tag, st_ff.ctr[a]});
                        end
                    end
                end
            end
            default: begin
                nxt_st.state = mcc_pkg::MCC_DEV_IDLE;
            end
        endcase

        // provisioning stands in for the root key and key update commands
        if (init_we_in) begin
            nxt_st.ctr[init_addr_in] = init_value_in;
            nxt_st.ctr_init[init_addr_in] = 1'b1;
            nxt_st.key[init_addr_in] = init_key_in;
            nxt_st.key_init[init_addr_in] = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_ff <= '0;
            st_ff.state <= mcc_pkg::MCC_DEV_IDLE;
            st_ff.sclk_q <= 1'b0;
            st_ff.cs_q <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lnk.miso = st_ff.miso;
    assign ctr_status_out = st_ff.status;

endmodule // mcc_dev
`default_nettype wire

// >>> rtl/mcc_host.sv
// controller end: builds signed counter frames, reads status/data, repolls while busy
`timescale 1ns/1ps
`default_nettype none
`include "mcc_regs.svh"
module mcc_host (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // serial link
    mcc_if.host lnk,
    // command request
    input wire logic start_in,
    input wire logic [1:0] cmd_in,
    input wire logic [7:0] sub_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] data_in,
    input wire logic [95:0] tag_in,
    input wire logic [255:0] key_in,
    // command answer
    output logic ready_out,
    output logic done_out,
    output logic [7:0] status_out,
    output logic [95:0] tag_out,
    output logic [31:0] ctr_out,
    output logic [255:0] sig_out
);

    mcc_pkg::mcc_hst_s st_ff;
    mcc_pkg::mcc_hst_s nxt_st;

    always_comb begin
        logic [7:0] rbyte;
        logic [255:0] sg;
        logic is_inc;
        int sbase;
        rbyte = {st_ff.rb[6:0], lnk.miso};
        is_inc = (cmd_in == mcc_pkg::MCC_CMD_INC);
        sbase = is_inc ? 8 : 16;
        sg = mcc_pkg::sign(key_in, mcc_pkg::ctr_msg(is_inc ? `MCC_SUB_INC : `MCC_SUB_REQ,
                                                    addr_in, 8'h00,
                                                    is_inc ? {64'h0, data_in} : tag_in));
        nxt_st = st_ff;
        nxt_st.done = 1'b0;

        case (st_ff.state)
            mcc_pkg::MCC_HST_IDLE: begin
                if (start_in) begin
                    nxt_st.tx = '0;
                    nxt_st.tx[0] = `MCC_OPC_CTR;
                    nxt_st.tx[2] = addr_in;
                    nxt_st.is_read = 1'b0;
                    nxt_st.status = 8'h00;
                    case (cmd_in)
                        mcc_pkg::MCC_CMD_INC: begin
                            // [RULE2] 40 byte increment frame
                            // [RULE6] current value sent
                            nxt_st.tx[1] = `MCC_SUB_INC;
                            nxt_st.len = `MCC_LEN_INC;
                            for (int k = 0; k < 4; k++) begin
                                nxt_st.tx[4 + k] = data_in[31 - 8 * k -: 8];
                            end
                        end
                        mcc_pkg::MCC_CMD_REQ: begin
                            // [RULE9] 48 byte request frame
                            nxt_st.tx[1] = `MCC_SUB_REQ;
                            nxt_st.len = `MCC_LEN_REQ;
                            for (int k = 0; k < 12; k++) begin
                                nxt_st.tx[4 + k] = tag_in[95 - 8 * k -: 8];
                            end
                        end
                        mcc_pkg::MCC_CMD_READ: begin
                            nxt_st.tx[0] = `MCC_OPC_READ;
                            nxt_st.tx[2] = 8'h00;
                            nxt_st.len = `MCC_LEN_READ;
                            nxt_st.is_read = 1'b1;
                        end
                        default: begin
                            nxt_st.tx[1] = sub_in;
                            nxt_st.len = `MCC_LEN_RSV;
                        end
                    endcase
                    if (cmd_in == mcc_pkg::MCC_CMD_INC || cmd_in == mcc_pkg::MCC_CMD_REQ) begin
                        for (int k = 0; k < 32; k++) begin
                            nxt_st.tx[sbase + k] = sg[255 - 8 * k -: 8];
                        end
                    end
                    nxt_st.state = mcc_pkg::MCC_HST_SHIFT;
                    nxt_st.cs_n = 1'b0;
                    nxt_st.div = 2'h0;
                    nxt_st.bit_cnt = 3'h0;
                    nxt_st.byte_idx = 7'h00;
                    nxt_st.last = 1'b0;
                    nxt_st.mosi = nxt_st.tx[0][7];
                end
            end
            mcc_pkg::MCC_HST_SHIFT: begin
                if (st_ff.div != `MCC_SCK_HALF) begin
                    nxt_st.div = st_ff.div + 2'h1;
                end else if (!st_ff.sclk) begin
                    nxt_st.div = 2'h0;
                    nxt_st.sclk = 1'b1;
                    nxt_st.rb = rbyte;
                    nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                    if (st_ff.is_read && st_ff.byte_idx > `MCC_RD_HDR) begin
                        nxt_st.fld = {st_ff.fld[382:0], lnk.miso};
                    end
                    if (st_ff.bit_cnt == 3'h7) begin
                        nxt_st.byte_idx = st_ff.byte_idx + 7'h01;
                        // [RULE18] never past 49 payload bytes
                        if (st_ff.byte_idx + 7'h01 == st_ff.len) begin
                            nxt_st.last = 1'b1;
                        end
                        if (st_ff.is_read && st_ff.byte_idx == `MCC_RD_HDR) begin
                            nxt_st.status = rbyte;
                            // [RULE16] error or busy: stop after status
                            // [RULE17] cut short by select
                            if (rbyte != `MCC_ST_OK) begin
                                nxt_st.last = 1'b1;
                            end
                        end
                    end
                end else begin
                    nxt_st.div = 2'h0;
                    nxt_st.sclk = 1'b0;
                    if (st_ff.last) begin
                        nxt_st.cs_n = 1'b1;
                        nxt_st.state = mcc_pkg::MCC_HST_GAP;
                        nxt_st.gap = 4'h0;
                    end else begin
                        nxt_st.mosi = (st_ff.byte_idx < `MCC_RX_BYTES)
                                      ? st_ff.tx[st_ff.byte_idx[5:0]][3'h7 - st_ff.bit_cnt] : 1'b0;
                    end
                end
            end
            mcc_pkg::MCC_HST_GAP: begin
                nxt_st.gap = st_ff.gap + 4'h1;
                // select stays high for a few cycles so the device sees a frame break
                if (st_ff.gap == `MCC_GAP_CYC) begin
                    if (st_ff.is_read && (st_ff.status & `MCC_ST_BUSY) != 8'h00) begin
                        // [RULE21] reread after busy
                        nxt_st.state = mcc_pkg::MCC_HST_SHIFT;
                        nxt_st.cs_n = 1'b0;
                        nxt_st.bit_cnt = 3'h0;
                        nxt_st.byte_idx = 7'h00;
                        nxt_st.last = 1'b0;
                        nxt_st.mosi = st_ff.tx[0][7];
                    end else begin
                        nxt_st.state = mcc_pkg::MCC_HST_IDLE;
                        nxt_st.done = 1'b1;
                        if (st_ff.is_read && st_ff.status == `MCC_ST_OK) begin
                            nxt_st.tag = st_ff.fld[383:288];
                            nxt_st.ctr = st_ff.fld[287:256];
                            nxt_st.sig = st_ff.fld[255:0];
                        end
                    end
                end
            end
            default: begin
                nxt_st.state = mcc_pkg::MCC_HST_IDLE;
            end
        endcase
        nxt_st.ready = (nxt_st.state == mcc_pkg::MCC_HST_IDLE);
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_ff <= '0;
            st_ff.state <= mcc_pkg::MCC_HST_IDLE;
            st_ff.cs_n <= 1'b1;
            st_ff.ready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lnk.cs_n = st_ff.cs_n;
    assign lnk.sclk = st_ff.sclk;
    assign lnk.mosi = st_ff.mosi;
    assign ready_out = st_ff.ready;
    assign done_out = st_ff.done;
    assign status_out = st_ff.status;
    assign tag_out = st_ff.tag;
    assign ctr_out = st_ff.ctr;
    assign sig_out = st_ff.sig;

endmodule // mcc_host
`default_nettype wire

// >>> sim/mcc_link_checker.sv
// wire-level checks on the serial link between the counter device and its controller
`timescale 1ns/1ps
`default_nettype none
module mcc_link_checker (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // serial link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    // rises per frame, modulo one byte
    logic [2:0] rise_cnt_ff;
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || cs_n) begin
            rise_cnt_ff <= 3'h0;
        end else if ($rose(sclk)) begin
            rise_cnt_ff <= rise_cnt_ff + 3'h1;
        end
    end

    // both opcodes 9bh and 96h open with bits 1,0,0,1
    sequence lead_bits_s;
        !sclk && mosi ##2 (sclk && mosi) ##4 (sclk && !mosi) ##4 (sclk && !mosi) ##4 (sclk && mosi);
    endsequence
    sequence high_phase_s;
        sclk ##1 !sclk;
    endsequence

    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("serial clock moves outside a frame");
    gap_hold_a: assert property ($rose(cs_n) |-> cs_n [*5])
        else $error("select gap between frames too short");
    sel_lead_a: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
        else $error("serial clock rises too soon after select");
    opcode_lead_a: assert property ($fell(cs_n) |-> lead_bits_s)
        else $error("frame does not open with a counter opcode");
    half_period_a: assert property ($changed(sclk) |=> $stable(sclk))
        else $error("serial clock half period shorter than two cycles");
    high_time_a: assert property ($rose(sclk) |=> high_phase_s)
        else $error("serial clock high phase not two cycles");
    low_time_a: assert property ($fell(sclk) && !cs_n |=> !sclk ##1 (sclk || cs_n))
        else $error("serial clock low phase not two cycles");
    mosi_hold_a: assert property (sclk |-> $stable(mosi))
        else $error("data line moved while serial clock high");
    whole_bytes_a: assert property ($rose(cs_n) |-> rise_cnt_ff == 3'h0)
        else $error("frame did not end on a byte boundary");
endmodule // mcc_link_checker
`default_nettype wire

// >>> sim/monotonic_counter_cmds_tb.sv
// self-checking bench: controller and device joined, answers checked from a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "mcc_regs.svh"
module monotonic_counter_cmds_tb;
    typedef struct packed {
        logic [7:0] st;
        logic full;
        logic [31:0] ctr;
        logic [95:0] tag;
        logic [255:0] sig;
    } mcc_note_s;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic init_we_in = 1'b0;
    logic [1:0] init_addr_in = 2'h0;
    logic [31:0] init_value_in = 32'h0;
    logic [255:0] init_key_in = 256'h0;
    logic start_in = 1'b0;
    logic [1:0] cmd_in = 2'h0;
    logic [7:0] sub_in = 8'h0;
    logic [7:0] addr_in = 8'h0;
    logic [31:0] data_in = 32'h0;
    logic [95:0] tag_in = 96'h0;
    logic [255:0] key_in = 256'h0;
    logic ready_out;
    logic done_out;
    logic [7:0] status_out;
    logic [7:0] ctr_status_out;
    logic [95:0] tag_out;
    logic [31:0] ctr_out;
    logic [255:0] sig_out;
    logic [31:0] rng = 32'hab1f7970;
    logic [31:0] mv [4];
    logic [255:0] mk [4];
    mcc_note_s q [$];
    int n_fail = 0;
    int n_tests = 0;

    mcc_if lnk();
    mcc_dev i_mcc_dev (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .lnk(lnk.dev),
        .init_we_in(init_we_in), .init_addr_in(init_addr_in), .init_value_in(init_value_in),
        .init_key_in(init_key_in), .ctr_status_out(ctr_status_out));
    mcc_host i_mcc_host (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .lnk(lnk.host),
        .start_in(start_in), .cmd_in(cmd_in), .sub_in(sub_in), .addr_in(addr_in),
        .data_in(data_in), .tag_in(tag_in), .key_in(key_in), .ready_out(ready_out),
        .done_out(done_out), .status_out(status_out), .tag_out(tag_out), .ctr_out(ctr_out),
        .sig_out(sig_out));
    mcc_link_checker i_mcc_link_checker (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .cs_n(lnk.cs_n), .sclk(lnk.sclk), .mosi(lnk.mosi));

    always #50 clock_in = ~clock_in;

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // reply signature of a request: key mixed with tag and counter
    function automatic logic [255:0] sgn(input logic [255:0] k, input logic [127:0] m);
        return {k[255:128] ^ m, k[127:0] ^ {m[63:0], m[127:64]}};
    endfunction

    task automatic cmp_st(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t status got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_dat(input logic [383:0] got, input logic [383:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t fields got %h exp %h", $time, got, exp);
        end
    endtask

    always @(negedge clock_in) begin
        if (done_out === 1'b1 && q.size() > 0) begin
            mcc_note_s n;
            n = q.pop_front();
            cmp_st(status_out, n.st);
            if (n.full) cmp_dat({tag_out, ctr_out, sig_out}, {n.tag, n.ctr, n.sig});
        end
    end

    task automatic go(input logic [1:0] c, input logic [7:0] s, input logic [7:0] a,
        input logic [31:0] d, input logic [95:0] t, input logic [255:0] k, input mcc_note_s n);
        @(negedge clock_in);
        cmd_in = c;
        sub_in = s;
        addr_in = a;
        data_in = d;
        tag_in = t;
        key_in = k;
        q.push_back(n);
        start_in = 1'b1;
        @(negedge clock_in);
        start_in = 1'b0;
        for (int i = 0; i < 9000 && (q.size() > 0 || ready_out !== 1'b1); i++) @(negedge clock_in);
        if (q.size() > 0 || ready_out !== 1'b1) n_fail++;
    endtask

    // one command, then a status/data read that repolls while busy
    task automatic op(input logic [1:0] c, input logic [7:0] s, input logic [7:0] a,
        input logic [31:0] d, input logic [95:0] t, input logic [255:0] k, input logic [7:0] st);
        logic [31:0] v;
        v = (a < 8'h4) ? mv[a[1:0]] : 32'h0;
        go(c, s, a, d, t, k, '0);
        if (st == `MCC_ST_OK) cmp_st(ctr_status_out, `MCC_ST_BUSY);
        go(2'h2, 8'h0, 8'h0, 32'h0, 96'h0, 256'h0,
            '{st, c == 2'h1 && st == `MCC_ST_OK, v, t, sgn(k, {t, v})});
        if (c == 2'h0 && st == `MCC_ST_OK) mv[a[1:0]] = mv[a[1:0]] + 32'h1;
        $display("test cmd %h type %h addr %h done", c, s, a);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] r;
        logic [7:0] subs [7];
        subs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hff, 8'h80};
        repeat (20) @(negedge clock_in);
        sys_rst_in = 1'b0;
        // counter three stays uninitialised on purpose
        for (int j = 0; j < 4; j++) begin
            mv[j] = rnd();
            mk[j] = {8{rnd()}};
            init_addr_in = j[1:0];
            init_value_in = mv[j];
            init_key_in = mk[j];
            init_we_in = (j < 3);
            @(negedge clock_in);
        end
        init_we_in = 1'b0;
        r = rnd();
        op(2'h0, 8'h0, 8'h0, mv[0], 96'h0, mk[0], `MCC_ST_OK);
        op(2'h0, 8'h0, 8'h0, mv[0], 96'h0, mk[0], `MCC_ST_OK);
        op(2'h1, 8'h0, 8'h0, 32'h0, {3{rnd()}}, mk[0], `MCC_ST_OK);
        op(2'h0, 8'h0, 8'h1, mv[1] + 32'h1, 96'h0, mk[1], `MCC_ST_DATA);
        op(2'h0, 8'h0, 8'h2, mv[2], 96'h0, ~mk[2], `MCC_ST_SIG);
        op(2'h1, 8'h0, 8'h3, 32'h0, {3{r}}, mk[3], `MCC_ST_NOINIT);
        op(2'h1, 8'h0, 8'h4 + {5'h0, r[2:0]}, 32'h0, 96'h0, mk[0], `MCC_ST_BAD);
        op(2'h1, 8'h0, 8'h1, 32'h0, {3{r}}, mk[1], `MCC_ST_OK);
        subs[6] = 8'h04 + (r[7:0] % 8'hfc);
        foreach (subs[j]) op(2'h3, subs[j], 8'h0, 32'h0, 96'h0, mk[0], `MCC_ST_BAD);
        end_of_test();
    end

    initial begin
        repeat (90000) @(posedge clock_in);
        n_fail++;
        end_of_test();
    end
endmodule // monotonic_counter_cmds_tb
`default_nettype wire
